// >>> inc/uepc_regs.vh
/*
 * Constants of the USB endpoint control block: register offsets, field
 * positions, reset values and interrupt layout. Assumes a 32-bit register
 * port with word-aligned byte addresses.
 */
`ifndef UEPC_REGS_VH
`define UEPC_REGS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define UEPC_EP_BASE 8'h00
`define UEPC_INT_STAT 8'h40
`define UEPC_INT_MASK 8'h44
`define UEPC_MODE 8'h48
`define UEPC_STALL_CLR 8'h4c

// ----------------------------------------------------------------------
// Endpoint control fields
// ----------------------------------------------------------------------
`define UEPC_HSHK_BIT 0
`define UEPC_STALL_BIT 1
`define UEPC_TXEN_BIT 2
`define UEPC_RXEN_BIT 3
`define UEPC_CONDIS_BIT 4
`define UEPC_RETRY_BIT 6
`define UEPC_LOW_SPEED_DIRECT_BIT 7
`define UEPC_EP_WMASK 8'hdd
`define UEPC_EPN_WMASK 8'h1d
`define UEPC_EP_RESET 8'h00

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define UEPC_IRQ_STALL 0
`define UEPC_IRQ_REJECT 1
`define UEPC_IRQ_NAK 2
`define UEPC_IRQ_WIDTH 3

`endif

// >>> design/uepc_endpoint_control.v
/*
 * Per-endpoint control of a USB controller: sixteen endpoint control
 * registers, token acceptance decode, host-mode low-speed and NAK retry
 * steering, and a small interrupt block. Assumes the protocol engine
 * presents one token per cycle as a one-cycle strobe and that register
 * port strobes never come together.
 */
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "uepc_regs.vh"

module uepc_endpoint_control (
    input wire clk_in,
    input wire srst_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire tok_valid_in,
    input wire [3:0] tok_ep_in,
    input wire [1:0] tok_kind_in,
    input wire stall_event_in,
    input wire [3:0] stall_ep_in,
    input wire nak_event_in,
    input wire low_speed_target_in,
    output wire tok_accept_out,
    output wire tok_reject_out,
    output wire tok_handshake_out,
    output wire low_speed_direct_out,
    output wire pre_token_needed_out,
    output wire nak_retry_out,
    output wire host_mode_out,
    output wire irq_out
);

// ----------------------------------------------------------------------
// Token kinds
// ----------------------------------------------------------------------
localparam [1:0] TOK_OUT = 2'h0;
localparam [1:0] TOK_IN = 2'h1;
localparam [1:0] TOK_SETUP = 2'h2;

// Sixteen control bytes packed side by side, endpoint n at bits 8n+7..8n
wire [127:0] endpoint_control_regs;
reg [2:0] int_stat_reg;
reg [2:0] int_mask_reg;
reg host_mode_reg;
wire [7:0] ep_sel;
wire [7:0] endpoint_zero_control;
wire ep_access;
wire [3:0] ep_idx;
reg [2:0] events;
reg tok_ok;

// Endpoint registers sit on words 0..15
assign ep_access = (addr_in[7:6] == 2'h0) && (addr_in[1:0] == 2'h0);
assign ep_idx = addr_in[5:2];
assign endpoint_zero_control = endpoint_control_regs[7:0];
assign ep_sel = endpoint_control_regs[tok_ep_in * 8 +: 8];

// ----------------------------------------------------------------------
// Write mask per endpoint
// ----------------------------------------------------------------------
function [7:0] wmask;
    input [3:0] idx;
    begin
        // Endpoint zero alone holds the host controls; bit 5 never stored
        wmask = (idx == 4'h0) ? `UEPC_EP_WMASK : `UEPC_EPN_WMASK;
    end
endfunction

// ----------------------------------------------------------------------
// Endpoint registers
// ----------------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 16; g = g + 1) begin : gen_ep
        localparam [3:0] IDX = g;
        reg [7:0] ctl_reg;
        reg [7:0] ctl_next;
        // Each endpoint owns its byte, so every register has a single driver
        always @* begin
            ctl_next = ctl_reg;
            if (wr_in && ep_access && ep_idx == IDX) begin
                // Stall status is hardware owned; software writes skip it
                ctl_next = (wdata_in[7:0] & wmask(IDX)) | (ctl_reg & 8'h02);
            end
            // Set wins over the write-one clear of the stall flag
            if (stall_event_in && stall_ep_in == IDX) begin
                ctl_next[`UEPC_STALL_BIT] = 1'b1;
            end else if (wr_in && addr_in == `UEPC_STALL_CLR && wdata_in[IDX]) begin
                ctl_next[`UEPC_STALL_BIT] = 1'b0;
            end
        end
        always @(posedge clk_in) begin
            if (srst_in) begin
                ctl_reg <= `UEPC_EP_RESET;
            end else begin
                ctl_reg <= ctl_next;
            end
        end
        assign endpoint_control_regs[g * 8 +: 8] = ctl_reg;
    end
endgenerate

// ----------------------------------------------------------------------
// Token decode
// ----------------------------------------------------------------------
always @* begin
    tok_ok = 1'b0;
    case (tok_kind_in)
        TOK_OUT: tok_ok = ep_sel[`UEPC_RXEN_BIT];
        TOK_IN: tok_ok = ep_sel[`UEPC_TXEN_BIT];
        // Control-disable only counts when both directions are on
        TOK_SETUP: tok_ok = ep_sel[`UEPC_RXEN_BIT] && ep_sel[`UEPC_TXEN_BIT] &&
            !ep_sel[`UEPC_CONDIS_BIT];
        default: tok_ok = 1'b0;
    endcase
end

assign tok_accept_out = tok_valid_in && tok_ok;
assign tok_reject_out = tok_valid_in && !tok_ok;
assign tok_handshake_out = tok_valid_in && tok_ok && ep_sel[`UEPC_HSHK_BIT];

// Host-only controls are forced off in device mode
assign host_mode_out = host_mode_reg;
assign low_speed_direct_out = host_mode_reg &&
    endpoint_zero_control[`UEPC_LOW_SPEED_DIRECT_BIT];
assign pre_token_needed_out = host_mode_reg && low_speed_target_in &&
    !endpoint_zero_control[`UEPC_LOW_SPEED_DIRECT_BIT];
assign nak_retry_out = host_mode_reg &&
    !endpoint_zero_control[`UEPC_RETRY_BIT];

// ----------------------------------------------------------------------
// Interrupts and control registers
// ----------------------------------------------------------------------
always @* begin
    events = 3'h0;
    events[`UEPC_IRQ_STALL] = stall_event_in;
    events[`UEPC_IRQ_REJECT] = tok_reject_out;
    // A NAK left for software only matters when retry is off
    events[`UEPC_IRQ_NAK] = nak_event_in && !nak_retry_out;
end

always @(posedge clk_in) begin
    if (srst_in) begin
        int_stat_reg <= 3'h0;
        int_mask_reg <= 3'h0;
        host_mode_reg <= 1'b0;
    end else begin
        if (wr_in && addr_in == `UEPC_INT_STAT) begin
            int_stat_reg <= (int_stat_reg & ~wdata_in[2:0]) | events;
        end else begin
            int_stat_reg <= int_stat_reg | events;
        end
        if (wr_in && addr_in == `UEPC_INT_MASK) begin
            int_mask_reg <= wdata_in[2:0];
        end
        if (wr_in && addr_in == `UEPC_MODE) begin
            host_mode_reg <= wdata_in[0];
        end
    end
end

assign irq_out = |(int_stat_reg & int_mask_reg);

// ----------------------------------------------------------------------
// Read port
// ----------------------------------------------------------------------
always @(posedge clk_in) begin
    if (srst_in) begin
        rdata_out <= 32'h0;
    end else if (rd_in) begin
        if (ep_access) begin
            rdata_out <= {24'h0, endpoint_control_regs[ep_idx * 8 +: 8]};
        end else if (addr_in == `UEPC_INT_STAT) begin
            rdata_out <= {29'h0, int_stat_reg};
        end else if (addr_in == `UEPC_INT_MASK) begin
            rdata_out <= {29'h0, int_mask_reg};
        end else if (addr_in == `UEPC_MODE) begin
            rdata_out <= {31'h0, host_mode_reg};
        end else begin
            rdata_out <= 32'h0;
        end
    end else begin
        rdata_out <= 32'h0;
    end
end

endmodule

// >>> dv/uepc_endpoint_control_chk.sv
/* Port checker for the endpoint control block.
   Sees only top ports; bound after the module. */
`timescale 1ns/1ps
`include "uepc_regs.vh"
module uepc_chk (
    input wire clk_in, input wire srst_in, input wire [7:0] addr_in,
    input wire [31:0] wdata_in, input wire wr_in, input wire rd_in,
    input wire [31:0] rdata_out, input wire tok_valid_in,
    input wire [3:0] tok_ep_in, input wire [1:0] tok_kind_in,
    input wire stall_event_in, input wire [3:0] stall_ep_in,
    input wire nak_event_in, input wire low_speed_target_in,
    input wire tok_accept_out, input wire tok_reject_out,
    input wire tok_handshake_out, input wire low_speed_direct_out,
    input wire pre_token_needed_out, input wire nak_retry_out,
    input wire host_mode_out, input wire irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    rd_only_a: assert property (rdata_out != 0 |-> $past(rd_in)) else $error("data, no read");
    upper_zero_a: assert property (rdata_out[31:8] == 0) else $error("upper set");
    bit5_zero_a: assert property ($past(rd_in && addr_in < 8'h40) |-> !rdata_out[5])
        else $error("bit5 set");
    epn_host_a: assert property ($past(rd_in && addr_in[7:6] == 0 && addr_in[5:2] != 0)
        |-> rdata_out[7:6] == 0) else $error("host bits on ep n");
    one_verdict_a: assert property (tok_valid_in |-> tok_accept_out != tok_reject_out)
        else $error("token verdict");
    quiet_bus_a: assert property (!tok_valid_in |-> !tok_accept_out && !tok_reject_out)
        else $error("verdict without token");
    hshk_acc_a: assert property (tok_handshake_out |-> tok_accept_out) else $error("hshk");
    ls_route_a: assert property (pre_token_needed_out |-> host_mode_out
        && low_speed_target_in && !low_speed_direct_out) else $error("pre token");
    host_only_a: assert property (low_speed_direct_out || nak_retry_out |-> host_mode_out)
        else $error("host control in device mode");
    mask_off_a: assert property (wr_in && addr_in == `UEPC_INT_MASK && wdata_in[2:0] == 0
        |=> !irq_out) else $error("irq while masked");
    reset_val_a: assert property ($fell(srst_in) |-> rdata_out == 0 && !irq_out
        && !host_mode_out) else $error("reset values");
    cover property (tok_valid_in && tok_accept_out && tok_kind_in == 2'd2);
    cover property (irq_out);
    cover property (pre_token_needed_out);
endmodule
bind uepc_endpoint_control uepc_chk chk (.*);

// >>> dv/uepc_usb_partner.sv
/* Bus partner: issues tokens, stall and NAK events.
   Assumes callers use one edge per call. */
`timescale 1ns/1ps
module uepc_usb_partner (
    input wire clk_in,
    output reg tok_valid_out = 0, output reg [3:0] tok_ep_out = 0,
    output reg [1:0] tok_kind_out = 0, output reg stall_out = 0,
    output reg [3:0] stall_ep_out = 0, output reg nak_out = 0, output reg ls_out = 0
);
    // Unused fields toggle, so a stale value never passes for a live one
    task drive(input v, input [3:0] ep, input [1:0] kind, input st, input nk, input ls);
        begin
            @(posedge clk_in);
            tok_valid_out <= v;
            tok_ep_out <= v ? ep : ~tok_ep_out;
            tok_kind_out <= v ? kind : ~tok_kind_out;
            stall_out <= st;
            stall_ep_out <= st ? ep : ~stall_ep_out;
            nak_out <= nk;
            ls_out <= ls;
            #1;
        end
    endtask
endmodule

// >>> dv/uepc_endpoint_control_tb.sv
/* Testbench: register port, tokens, stall irq, host mode.
   Assumes uepc_regs.vh on the include path. */
`timescale 1ns/1ps
`include "uepc_regs.vh"
module uepc_endpoint_control_tb;
    reg clk_in = 0, srst_in = 1, wr_in = 0, rd_in = 0;
    reg [7:0] addr_in = 0;
    reg [7:0] img [0:15];
    reg [31:0] wdata_in = 0, d;
    wire [31:0] rdata_out;
    wire tv, st, nk, ls, acc, rej, hs, lsd, pre, nr, host, irq;
    wire [3:0] tep, sep;
    wire [1:0] tk;
    integer seed = 32'h284e, mismatches = 0, cmp_count = 0, i, k;
    always #2.5 clk_in = ~clk_in;
    uepc_usb_partner p (.clk_in(clk_in), .tok_valid_out(tv), .tok_ep_out(tep),
        .tok_kind_out(tk), .stall_out(st), .stall_ep_out(sep), .nak_out(nk), .ls_out(ls));
    uepc_endpoint_control dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .tok_valid_in(tv), .tok_ep_in(tep), .tok_kind_in(tk), .stall_event_in(st),
        .stall_ep_in(sep), .nak_event_in(nk), .low_speed_target_in(ls),
        .tok_accept_out(acc), .tok_reject_out(rej), .tok_handshake_out(hs),
        .low_speed_direct_out(lsd), .pre_token_needed_out(pre), .nak_retry_out(nr),
        .host_mode_out(host), .irq_out(irq));
    task chk(input [31:0] exp, input [31:0] got, input [8*6:1] what);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge clk_in);
            wr_in <= 1;
            addr_in <= a;
            wdata_in <= v;
            @(posedge clk_in);
            wr_in <= 0;
            #1;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk_in);
            rd_in <= 1;
            addr_in <= a;
            @(posedge clk_in);
            rd_in <= 0;
            #1;
            chk(exp, rdata_out, "rdata");
        end
    endtask
    // Accept and handshake expected for a config and a token kind
    function [1:0] tok_exp(input [7:0] c, input [1:0] kind);
        reg a;
        begin
            case (kind)
                2'd0: a = c[3];
                2'd1: a = c[2];
                2'd2: a = c[3] & c[2] & ~c[4];
                default: a = 0;
            endcase
            tok_exp = {a, a & c[0]};
        end
    endfunction
    task results;
        begin
            $display("checks %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 0;
        for (i = 0; i < 16; i = i + 1) rd({i[5:0], 2'b00}, 0);
        for (i = 0; i < 16; i = i + 1) begin
            d = $random(seed);
            img[i] = d[7:0] & (i == 0 ? `UEPC_EP_WMASK : `UEPC_EPN_WMASK);
            wr({i[5:0], 2'b00}, d);
        end
        for (i = 0; i < 16; i = i + 1) rd({i[5:0], 2'b00}, img[i]);
        wr(8'h50, 32'hffffffff);
        rd(8'h50, 0);
        $display("test registers done");
        wr(`UEPC_INT_MASK, 0);
        p.drive(0, 4'd5, 0, 1, 0, 0);
        p.drive(0, 0, 0, 0, 0, 0);
        rd(8'h14, img[5] | 8'h02);
        chk(0, irq, "irq");
        wr(`UEPC_INT_MASK, 1);
        chk(1, irq, "irq");
        wr(`UEPC_INT_STAT, 1);
        chk(0, irq, "irq");
        wr(`UEPC_STALL_CLR, 32'h20);
        rd(8'h14, img[5]);
        $display("test stall done");
        wr(`UEPC_MODE, 1);
        wr(0, 8'h80);
        p.drive(0, 0, 0, 0, 1, 1);
        p.drive(0, 0, 0, 0, 0, 1);
        chk(3'b101, {lsd, pre, nr}, "host");
        rd(`UEPC_INT_STAT, 0);
        wr(0, 8'h40);
        chk(3'b010, {lsd, pre, nr}, "host");
        p.drive(0, 0, 0, 0, 1, 1);
        p.drive(0, 0, 0, 0, 0, 1);
        rd(`UEPC_INT_STAT, 4);
        wr(`UEPC_MODE, 0);
        $display("test host done");
        for (i = 0; i < 32; i = i + 1) begin
            d = $random(seed);
            wr({2'b00, d[3:0], 2'b00}, i);
            for (k = 0; k < 4; k = k + 1) begin
                p.drive(1, d[3:0], k[1:0], 0, 0, 0);
                chk(tok_exp(i[7:0], k[1:0]), {acc, hs}, "token");
            end
            p.drive(0, 0, 0, 0, 0, 0);
        end
        $display("test tokens done");
        results;
    end
endmodule
